// [testbench/lintrx_mcu.sv]
`timescale 1ns/100ps
`default_nettype none
module lintrx_mcu
    import lintrx_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              clr,
    input  wire logic [NUM_CH-1:0] tx_level,
    input  wire logic [NUM_CH-1:0] rx,
    output var  logic [NUM_CH-1:0] tx,
    output var  logic [NUM_CH-1:0] rx_low_seen
);
    initial
    begin
        tx = '1;
        rx_low_seen = '0;
    end
    // port pins change off the sampling edge, as a real controller would
    always @(negedge clk)
    begin
        tx <= tx_level;
    end
    // latched so a short low on rx is not lost between polls
    always @(posedge clk)
    begin
        rx_low_seen <= clr ? '0 : (rx_low_seen | ~rx);
    end
endmodule
`default_nettype wire

// [testbench/lintrx_top_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module lintrx_top_tb
    import lintrx_pkg::*;
;
    localparam int TO    = 200;
    localparam int LIMIT = 80000;
    localparam int WK    = 7600;
    typedef struct {logic [1:0] mode; logic [2:0] sbc; logic drv; logic rx;} lintrx_row_type;
    logic                clk, rst, cmd, todis, uv, lss, byp, csn, wdb, clr;
    logic [7:0]          mfs;
    logic [2:0]          sbc;
    logic [NUM_CH-1:0]   txl, ext;
    wire  [NUM_CH-1:0]   tx_w, bus_w, rx_seen;
    logic [NUM_CH-1:0]   drv, rxo, flt, wks;
    logic                int_n, rr, wd, ls, bp;
    logic                int_seen, rr_seen, wd_seen;
    int                  err_count, cmp_count, cycles;
    lintrx_row_type      rows [7];

    // the other node pulls the wire low too, so the wire is an and of both
    assign bus_w = ext & ~drv;

    lintrx_top #(.TIMEOUT_CYCLES(TO)) uut (
        .clk(clk), .rst(rst),
        .channel1_mode_field(mfs[1:0]), .channel2_mode_field(mfs[3:2]),
        .channel3_mode_field(mfs[5:4]), .channel4_mode_field(mfs[7:6]),
        .sbc_mode(sbc), .sbc_mode_cmd(cmd), .bus_tx_input(tx_w), .bus_line_in(bus_w),
        .tx_timeout_disable(todis), .bus_supply_uv(uv), .low_slope_select(lss),
        .slope_bypass(byp), .spi_cs_n(csn), .watchdog_on_bus_wake(wdb),
        .bus_drive_dom(drv), .bus_rx_output(rxo), .channel_fault_flag(flt),
        .wake_status_reg(wks), .int_n_reg(int_n), .restart_req_reg(rr),
        .watchdog_enable_req_reg(wd), .low_slope_reg(ls), .slope_bypass_reg(bp));

    lintrx_mcu mcu (.clk(clk), .clr(clr), .tx_level(txl), .rx(rxo), .tx(tx_w),
        .rx_low_seen(rx_seen));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // pulses last one cycle, so they are caught here rather than polled
    always @(posedge clk)
    begin
        int_seen <= clr ? 1'b0 : (int_seen | ~int_n);
        rr_seen <= clr ? 1'b0 : (rr_seen | rr);
        wd_seen <= clr ? 1'b0 : (wd_seen | wd);
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            err_count++;
            give_verdict();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic done(input string name);
        $display("test %s finished, %0d mismatches so far", name, err_count);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic do_reset();
        rst = 1'b1;
        cyc(20);
        rst = 1'b0;
        cyc(4);
    endtask

    task automatic set_sbc(input logic [2:0] m);
        sbc = m;
        cmd = 1'b1;
        cyc(3);
        cmd = 1'b0;
        cyc(4);
    endtask

    // status must not move while dominant; the wake fires on the release
    task automatic wake(input int ch, input int len);
        logic [NUM_CH-1:0] w;
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
        w = wks;
        ext[ch] = 1'b0;
        cyc(len);
        chk(wks, w);
        ext[ch] = 1'b1;
        cyc(12);
    endtask

    initial
    begin
        rst = 1'b1;
        cmd = 1'b0;
        todis = 1'b0;
        uv = 1'b0;
        lss = 1'b0;
        byp = 1'b0;
        csn = 1'b1;
        wdb = 1'b0;
        clr = 1'b0;
        mfs = 8'h00;
        sbc = SBC_NORMAL;
        txl = '1;
        ext = '1;
        err_count = 0;
        cmp_count = 0;
        cycles = 0;
        // channels that end up off or unwoken leave rx recessive
        rows = '{'{MODE_NORMAL, SBC_NORMAL, 1'b1, 1'b0}, '{MODE_NORMAL, SBC_STOP, 1'b0, 1'b1},
            '{MODE_RXONLY, SBC_NORMAL, 1'b0, 1'b0}, '{MODE_RXONLY, SBC_STOP, 1'b0, 1'b0},
            '{MODE_RXONLY, SBC_SLEEP, 1'b0, 1'b1}, '{MODE_OFF, SBC_NORMAL, 1'b0, 1'b1},
            '{MODE_WAKE, SBC_NORMAL, 1'b0, 1'b1}};
        do_reset();
        chk({drv, rxo}, 8'h0F);
        chk({flt, wks}, 8'h00);
        chk({int_n, ls, bp}, 8'h04);
        done("reset");
        for (int i = 0; i < 7; i++)
        begin
            mfs = {4{rows[i].mode}};
            set_sbc(rows[i].sbc);
            cyc(EN_CYC + 20);
            txl = '0;
            cyc(10);
            chk(drv, {4{rows[i].drv}});
            ext = '0;
            cyc(10);
            chk(rxo, {4{rows[i].rx}});
            txl = '1;
            ext = '1;
            mfs = 8'h00;
            cyc(10);
        end
        done("mode table");
        set_sbc(SBC_NORMAL);
        mfs = {4{MODE_NORMAL}};
        // the second low is held through the enable delay, past the time-out; keep it from flagging a fault
        todis = 1'b1;
        txl = '0;
        cyc(100);
        txl = '1;
        cyc(5);
        txl = '0;
        cyc(10);
        chk(drv, 8'h00);
        cyc(EN_CYC);
        chk(drv, 8'h00);
        txl = '1;
        todis = 1'b0;
        cyc(5);
        txl = '0;
        cyc(10);
        chk(drv, 8'h0F);
        chk(flt, 8'h00);
        uv = 1'b1;
        ext = '0;
        cyc(10);
        chk({drv, rxo}, 8'h00);
        uv = 1'b0;
        ext = '1;
        txl = '1;
        cyc(5);
        txl = '0;
        cyc(10);
        chk(drv, 8'h0F);
        done("enable and undervoltage");
        txl = '1;
        cyc(5);
        txl = 4'hE;
        cyc(TO + 20);
        chk({drv, flt}, 8'h01);
        txl = '1;
        cyc(5);
        txl = 4'hE;
        cyc(10);
        chk(drv, 8'h01);
        todis = 1'b1;
        txl = 4'hD;
        cyc(TO + 20);
        chk({drv, flt}, 8'h23);
        todis = 1'b0;
        txl = '1;
        mfs[5:4] = MODE_RXONLY;
        ext = 4'hB;
        cyc(TO + 20);
        chk(flt, 8'h07);
        ext = '1;
        done("time-out and clamp");
        mfs = 8'h00;
        do_reset();
        chk(flt, 8'h00);
        wake(0, WK);
        chk(wks, 8'h00);
        mfs = {4{MODE_WAKE}};
        cyc(10);
        wake(0, 1000);
        chk(wks, 8'h00);
        wake(0, WK);
        chk({wks, rxo}, 8'h1E);
        chk({int_seen, rr_seen}, 8'h02);
        chk(rx_seen, 8'h01);
        cyc(200);
        chk({rxo[0], mfs[1:0]}, 8'h01);
        set_sbc(SBC_SLEEP);
        wake(1, WK);
        chk({int_seen, rr_seen}, 8'h01);
        chk({wks[1], rxo[1]}, 8'h02);
        chk(rx_seen, 8'h02);
        wdb = 1'b1;
        set_sbc(SBC_STOP);
        wake(2, WK);
        chk({int_seen, rr_seen, wd_seen}, 8'h05);
        set_sbc(SBC_STOP);
        wake(2, WK);
        chk(int_seen, 8'h01);
        set_sbc(SBC_NORMAL);
        mfs[5:4] = MODE_OFF;
        cyc(10);
        chk(rxo[2], 8'h01);
        mfs[5:4] = MODE_WAKE;
        cyc(10);
        wake(2, WK);
        chk(int_seen, 8'h01);
        mfs = 8'h00;
        set_sbc(SBC_FAILSAFE);
        wake(3, WK);
        chk({wks[3], rr_seen, int_seen}, 8'h06);
        done("wake");
        set_sbc(SBC_NORMAL);
        lss = 1'b1;
        byp = 1'b1;
        csn = 1'b0;
        cyc(10);
        chk({ls, bp}, 8'h00);
        csn = 1'b1;
        cyc(10);
        chk({ls, bp}, 8'h03);
        set_sbc(SBC_STOP);
        lss = 1'b0;
        byp = 1'b0;
        csn = 1'b0;
        cyc(5);
        csn = 1'b1;
        cyc(10);
        chk({ls, bp}, 8'h03);
        done("slope");
        give_verdict();
    end
endmodule
`default_nettype wire

// [verilog/lintrx_chan.sv]
`timescale 1ns/100ps
`default_nettype none
module lintrx_chan
    import lintrx_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
)
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [1:0] mode_field,
    input  wire logic [2:0] sbc_mode,
    input  wire logic       sbc_enter_rearm,
    input  wire logic       tx_in,
    input  wire logic       bus_in,
    input  wire logic       tx_timeout_disable,
    input  wire logic       supply_uv,
    output logic            drive_dom_reg,
    output logic            rx_out_reg,
    output logic            fault_flag_reg,
    output logic            wake_pulse_reg
);
    typedef enum logic [1:0] {ST_IDLE, ST_DOM, ST_WAIT} lintrx_wk_type;
    lintrx_wk_type          wk_reg;
    logic [1:0]             eff_mode;
    logic [1:0]             mode_prev_reg;
    logic [CNT_W-1:0]       en_cnt_reg;
    logic                   en_ok_reg;
    logic [CNT_W-1:0]       wk_cnt_reg;
    logic                   woken_reg;
    logic [CNT_W-1:0]       txto_cnt_reg;
    logic                   txto_reg;
    logic [CNT_W-1:0]       busto_cnt_reg;
    logic                   bus_prev_reg;
    logic                   tx_allowed;

    always_comb
    begin
        eff_mode = mode_field;
        if (sbc_mode == SBC_FAILSAFE)
            eff_mode = MODE_WAKE;
        else if (mode_field == MODE_NORMAL && sbc_mode != SBC_NORMAL)
            eff_mode = MODE_OFF;
        else if (mode_field == MODE_RXONLY && sbc_mode != SBC_NORMAL && sbc_mode != SBC_STOP)
            eff_mode = MODE_OFF;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            mode_prev_reg <= MODE_OFF;
        else
            mode_prev_reg <= eff_mode;
    end

    // enable delay, then a recessive tx must be seen before dominant passes
    always_ff @(posedge clk)
    begin
        if (rst || eff_mode != MODE_NORMAL || mode_prev_reg != MODE_NORMAL)
        begin
            en_cnt_reg <= '0;
            en_ok_reg  <= 1'b0;
        end
        else if (en_cnt_reg < CNT_W'(EN_CYC))
            en_cnt_reg <= en_cnt_reg + CNT_W'(1);
        else if (tx_in)
            en_ok_reg <= 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (rst || tx_timeout_disable || tx_in || eff_mode != MODE_NORMAL)
        begin
            txto_cnt_reg <= '0;
            txto_reg     <= 1'b0;
        end
        else if (txto_cnt_reg < CNT_W'(TIMEOUT_CYCLES))
            txto_cnt_reg <= txto_cnt_reg + CNT_W'(1);
        else
            txto_reg <= 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (rst || bus_in || (eff_mode != MODE_NORMAL && eff_mode != MODE_RXONLY))
            busto_cnt_reg <= '0;
        else if (busto_cnt_reg <= CNT_W'(TIMEOUT_CYCLES))
            busto_cnt_reg <= busto_cnt_reg + CNT_W'(1);
    end

    // fault stays set; reset wins, cleared only by reset since no clear path exists
    always_ff @(posedge clk)
    begin
        if (rst)
            fault_flag_reg <= 1'b0;
        else if (txto_cnt_reg == CNT_W'(TIMEOUT_CYCLES) && !tx_in)
            fault_flag_reg <= 1'b1;
        else if (busto_cnt_reg == CNT_W'(TIMEOUT_CYCLES))
            fault_flag_reg <= 1'b1;
    end

    assign tx_allowed = eff_mode == MODE_NORMAL && en_ok_reg && !txto_reg && !supply_uv;

    always_ff @(posedge clk)
    begin
        if (rst)
            drive_dom_reg <= 1'b0;
        else
            drive_dom_reg <= tx_allowed && !tx_in;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            bus_prev_reg <= 1'b1;
        else
            bus_prev_reg <= bus_in;
    end

    // wake detector; leaving wake mode or a chip-mode rearm clears it
    always_ff @(posedge clk)
    begin
        if (rst || eff_mode != MODE_WAKE || sbc_enter_rearm)
        begin
            wk_reg         <= ST_IDLE;
            wk_cnt_reg     <= '0;
            woken_reg      <= 1'b0;
            wake_pulse_reg <= 1'b0;
        end
        else
        begin
            wake_pulse_reg <= 1'b0;
            case (wk_reg)
                ST_IDLE:
                begin
                    wk_cnt_reg <= '0;
                    if (!woken_reg && bus_prev_reg && !bus_in)
                        wk_reg <= ST_DOM;
                end
                ST_DOM:
                begin
                    if (bus_in)
                        wk_reg <= ST_IDLE;
                    else if (wk_cnt_reg >= CNT_W'(WAKE_CYC))
                        wk_reg <= ST_WAIT;
                    else
                        wk_cnt_reg <= wk_cnt_reg + CNT_W'(1);
                end
                ST_WAIT:
                begin
                    if (bus_in)
                    begin
                        wk_reg         <= ST_IDLE;
                        woken_reg      <= 1'b1;
                        wake_pulse_reg <= 1'b1;
                    end
                end
                default:
                    wk_reg <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            rx_out_reg <= 1'b1;
        else if (eff_mode == MODE_WAKE && woken_reg)
            rx_out_reg <= 1'b0;
        else if (eff_mode == MODE_NORMAL || eff_mode == MODE_RXONLY)
            rx_out_reg <= bus_in;
        else
            rx_out_reg <= 1'b1;
    end

    // wake fired and the channel stayed in wake mode without a rearm
    sequence s_woken_held;
        wake_pulse_reg ##1 (eff_mode == MODE_WAKE && !sbc_enter_rearm);
    endsequence

    a_drive_needs_enable: assert property (@(posedge clk) disable iff (rst)
        drive_dom_reg |-> $past(en_ok_reg)) else $error("driven before enable");
    a_uv_blocks_drive: assert property (@(posedge clk) disable iff (rst)
        $past(supply_uv) |-> !drive_dom_reg) else $error("drive under uv");
    a_off_no_wake: assert property (@(posedge clk) disable iff (rst)
        $past(eff_mode) == MODE_OFF |-> !wake_pulse_reg) else $error("wake in off");
    a_rx_held_low: assert property (@(posedge clk) disable iff (rst)
        s_woken_held |-> !rx_out_reg)
        else $error("rx not low after wake");
    a_txto_blocks: assert property (@(posedge clk) disable iff (rst)
        $past(txto_reg) |-> !drive_dom_reg) else $error("drive after timeout");
    a_txto_disable: assert property (@(posedge clk) disable iff (rst)
        tx_timeout_disable |=> !txto_reg) else $error("timeout while disabled");
    a_fault_sticky: assert property (@(posedge clk) disable iff (rst)
        fault_flag_reg |=> fault_flag_reg) else $error("fault flag lost");
    a_normal_only: assert property (@(posedge clk) disable iff (rst)
        drive_dom_reg |-> $past(sbc_mode) == SBC_NORMAL) else $error("drive outside normal");
endmodule
`default_nettype wire

// [verilog/lintrx_pkg.sv]
package lintrx_pkg;
    localparam int           CLK_MHZ        = 50;
    localparam int           NUM_CH         = 4;
    localparam logic [1:0]   MODE_OFF       = 2'h0;
    localparam logic [1:0]   MODE_WAKE      = 2'h1;
    localparam logic [1:0]   MODE_RXONLY    = 2'h2;
    localparam logic [1:0]   MODE_NORMAL    = 2'h3;
    localparam int           WAKE_FILTER_US = 50;
    localparam int           WAKE_CYC       = WAKE_FILTER_US * CLK_MHZ;
    localparam int           EN_DELAY_US    = 10;
    localparam int           EN_CYC         = EN_DELAY_US * CLK_MHZ;
    localparam int           TIMEOUT_US     = 12000;
    localparam int           TIMEOUT_CYC    = TIMEOUT_US * CLK_MHZ;
    localparam logic [2:0]   SBC_NORMAL     = 3'h0;
    localparam logic [2:0]   SBC_STOP       = 3'h1;
    localparam logic [2:0]   SBC_SLEEP      = 3'h2;
    localparam logic [2:0]   SBC_RESTART    = 3'h3;
    localparam logic [2:0]   SBC_FAILSAFE   = 3'h4;
    localparam int           CNT_W          = 20;
endpackage

// [verilog/lintrx_top.sv]
`timescale 1ns/100ps
`default_nettype none
module lintrx_top
    import lintrx_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
)
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [1:0]        channel1_mode_field,
    input  wire logic [1:0]        channel2_mode_field,
    input  wire logic [1:0]        channel3_mode_field,
    input  wire logic [1:0]        channel4_mode_field,
    input  wire logic [2:0]        sbc_mode,
    input  wire logic              sbc_mode_cmd,
    input  wire logic [NUM_CH-1:0] bus_tx_input,
    input  wire logic [NUM_CH-1:0] bus_line_in,
    input  wire logic              tx_timeout_disable,
    input  wire logic              bus_supply_uv,
    input  wire logic              low_slope_select,
    input  wire logic              slope_bypass,
    input  wire logic              spi_cs_n,
    input  wire logic              watchdog_on_bus_wake,
    output logic [NUM_CH-1:0]      bus_drive_dom,
    output logic [NUM_CH-1:0]      bus_rx_output,
    output logic [NUM_CH-1:0]      channel_fault_flag,
    output logic [NUM_CH-1:0]      wake_status_reg,
    output logic                   int_n_reg,
    output logic                   restart_req_reg,
    output logic                   watchdog_enable_req_reg,
    output logic                   low_slope_reg,
    output logic                   slope_bypass_reg
);
    logic [1:0]        mode_arr [NUM_CH];
    logic [NUM_CH-1:0] tx_s1_reg, tx_s2_reg, bus_s1_reg, bus_s2_reg, wake_p;
    logic [2:0]        sm_s1_reg, sm_s2_reg, sm_prev_reg;
    logic              cmd_s1_reg, cmd_s2_reg, cmd_prev_reg, uv_s1_reg, uv_s2_reg;
    logic              to_s1_reg, to_s2_reg, cs_s1_reg, cs_s2_reg, cs_prev_reg;
    logic              ls_s1_reg, ls_s2_reg, fb_s1_reg, fb_s2_reg, wd_s1_reg, wd_s2_reg;
    logic              rearm;

    assign mode_arr[0] = channel1_mode_field;
    assign mode_arr[1] = channel2_mode_field;
    assign mode_arr[2] = channel3_mode_field;
    assign mode_arr[3] = channel4_mode_field;

    // pins other than the mode fields and reset cross in through two flip-flops
    always_ff @(posedge clk)
    begin
        tx_s1_reg  <= bus_tx_input;
        tx_s2_reg  <= tx_s1_reg;
        bus_s1_reg <= bus_line_in;
        bus_s2_reg <= bus_s1_reg;
        sm_s1_reg  <= sbc_mode;
        sm_s2_reg  <= sm_s1_reg;
        cmd_s1_reg <= sbc_mode_cmd;
        cmd_s2_reg <= cmd_s1_reg;
        uv_s1_reg  <= bus_supply_uv;
        uv_s2_reg  <= uv_s1_reg;
        to_s1_reg  <= tx_timeout_disable;
        to_s2_reg  <= to_s1_reg;
        cs_s1_reg  <= spi_cs_n;
        cs_s2_reg  <= cs_s1_reg;
        ls_s1_reg  <= low_slope_select;
        ls_s2_reg  <= ls_s1_reg;
        fb_s1_reg  <= slope_bypass;
        fb_s2_reg  <= fb_s1_reg;
        wd_s1_reg  <= watchdog_on_bus_wake;
        wd_s2_reg  <= wd_s1_reg;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sm_prev_reg  <= SBC_NORMAL;
            cmd_prev_reg <= 1'b0;
            cs_prev_reg  <= 1'b1;
        end
        else
        begin
            sm_prev_reg  <= sm_s2_reg;
            cmd_prev_reg <= cmd_s2_reg;
            cs_prev_reg  <= cs_s2_reg;
        end
    end

    // a repeated stop command also rearms
    assign rearm = (sm_s2_reg != sm_prev_reg && (sm_s2_reg == SBC_STOP || sm_s2_reg == SBC_SLEEP
                    || sm_s2_reg == SBC_FAILSAFE))
                   || (sm_s2_reg == SBC_STOP && cmd_s2_reg && !cmd_prev_reg);

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++)
        begin : g_ch
            lintrx_chan #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_ch (
                .clk                (clk),
                .rst                (rst),
                .mode_field         (mode_arr[g]),
                .sbc_mode           (sm_s2_reg),
                .sbc_enter_rearm    (rearm),
                .tx_in              (tx_s2_reg[g]),
                .bus_in             (bus_s2_reg[g]),
                .tx_timeout_disable (to_s2_reg),
                .supply_uv          (uv_s2_reg),
                .drive_dom_reg      (bus_drive_dom[g]),
                .rx_out_reg         (bus_rx_output[g]),
                .fault_flag_reg     (channel_fault_flag[g]),
                .wake_pulse_reg     (wake_p[g])
            );
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wake_status_reg         <= '0;
            int_n_reg               <= 1'b1;
            restart_req_reg         <= 1'b0;
            watchdog_enable_req_reg <= 1'b0;
        end
        else
        begin
            wake_status_reg <= wake_status_reg | wake_p;
            int_n_reg <= !(|wake_p && (sm_s2_reg == SBC_NORMAL || sm_s2_reg == SBC_STOP));
            restart_req_reg <= |wake_p && sm_s2_reg != SBC_NORMAL && sm_s2_reg != SBC_STOP;
            watchdog_enable_req_reg <= |wake_p && sm_s2_reg == SBC_STOP && wd_s2_reg;
        end
    end

    // slope settings latch at chip select rise, only in normal mode
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            low_slope_reg    <= 1'b0;
            slope_bypass_reg <= 1'b0;
        end
        else if (cs_s2_reg && !cs_prev_reg && sm_s2_reg == SBC_NORMAL)
        begin
            low_slope_reg    <= ls_s2_reg;
            slope_bypass_reg <= fb_s2_reg;
        end
    end

    a_int_stop_wake: assert property (@(posedge clk) disable iff (rst)
        (|wake_p && sm_s2_reg == SBC_STOP) |=> !int_n_reg) else $error("no int");
    a_sleep_restart: assert property (@(posedge clk) disable iff (rst)
        (|wake_p && sm_s2_reg == SBC_SLEEP) |=> restart_req_reg && int_n_reg)
        else $error("no restart");
    a_wd_enable: assert property (@(posedge clk) disable iff (rst)
        (|wake_p && sm_s2_reg == SBC_STOP && wd_s2_reg) |=> watchdog_enable_req_reg)
        else $error("no wd enable");
    a_slope_hold: assert property (@(posedge clk) disable iff (rst)
        !(cs_s2_reg && !cs_prev_reg) |=> $stable(low_slope_reg)) else $error("slope moved");
endmodule
`default_nettype wire
